// ==== tss_evt_if.sv ====
// Carries the per-block sync pulses and hold flags between modules.
// Assumes all ends share the system clock.
interface tss_evt_if;
    logic [4:0] pulse;
    logic off_hold;
    logic gp_hold;
    // Producer of the events
    modport src (output pulse, output off_hold, output gp_hold);
    // Consumer of the events
    modport dst (input pulse, input off_hold, input gp_hold);
endinterface : tss_evt_if

// ==== tss_host_model.sv ====
// Host-side partner for the transmit sync control: register access
// and the external sync pin.
// Assumes the register port is sampled on the rising edge of clk_sys.
module tss_host_model
(
    // Clock
    input wire logic clk_sys,
    // Register port
    output logic reg_wr,
    output logic reg_rd,
    output logic [8:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    // External sync pin
    output logic sync_pin
);
    timeunit 1ns;
    timeprecision 1ns;

    // =========================================================
    // Idle levels at time zero
    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 9'h000;
        reg_wdata = 8'h00;
        sync_pin = 1'b0;
    end

    // =========================================================
    // Register write: one strobe cycle, then address and data scrambled
    task automatic wr(input logic [8:0] addr, input logic [7:0] data);
        @(posedge clk_sys);
        #1;
        reg_wr = 1'b1;
        reg_addr = addr;
        reg_wdata = data;
        @(posedge clk_sys);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~addr;
        reg_wdata = ~data;
    endtask : wr

    // Register read: answer taken at the edge after the strobe
    task automatic rd(input logic [8:0] addr, output logic [7:0] data, output logic valid);
        @(posedge clk_sys);
        #1;
        reg_rd = 1'b1;
        reg_addr = addr;
        @(posedge clk_sys);
        #1;
        valid = reg_rvalid;
        data = reg_rdata;
        reg_rd = 1'b0;
        reg_addr = ~addr;
    endtask : rd

    // Soft trigger: clear the bits first so that setting them is a fresh edge
    task automatic trig(input logic [7:0] mask);
        wr(9'h10d, 8'h00);
        wr(9'h10d, mask);
    endtask : trig

    // Pin edge: low for three cycles, then high until the next call
    task automatic pin_rise();
        @(posedge clk_sys);
        #1;
        sync_pin = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        sync_pin = 1'b1;
    endtask : pin_rise
endmodule : tss_host_model

// ==== tss_pin_sync.sv ====
// Two-stage synchroniser for the sync pin with a rising-edge pulse.
// Assumes the pin is asynchronous to clk_sys.
module tss_pin_sync
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Pin in, edge out
    input wire logic pin,
    output logic rise
);
    typedef struct packed {
        logic meta;
        logic stable;
        logic last;
        logic rise;
    } tss_ps_t;
    tss_ps_t st;
    tss_ps_t next_st;

    // =========================================================
    // Next state: only the second stage feeds the edge logic
    always_comb
    begin
        next_st = st;
        next_st.meta = pin;
        next_st.stable = st.meta;
        next_st.last = st.stable;
        next_st.rise = st.stable & ~st.last;
    end

    // State register
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            st <= '0;
        else
            st <= next_st;
    end

    assign rise = st.rise;

    // One pulse per edge, never two in a row
    a_pin_single_pulse: assert property (@(posedge clk_sys) disable iff (!resetn)
        rise |=> !rise)
        else $error("pin edge pulse longer than one cycle");
endmodule : tss_pin_sync

// ==== tss_pkg.sv ====
// Constants and types for the transmit sync distribution control.
// Assumes one 10 MHz clock domain shared by all users of the package.
package tss_pkg;
    // =========================================================
    // Register offsets
    localparam logic [8:0] TSS_ADDR_DIS = 9'h10b;
    localparam logic [8:0] TSS_ADDR_SRC = 9'h10c;
    localparam logic [8:0] TSS_ADDR_TRIG = 9'h10d;
    localparam logic [8:0] TSS_ADDR_CORR = 9'h10e;
    // =========================================================
    // Reset values
    localparam logic [7:0] TSS_RST_DIS = 8'h00;
    localparam logic [7:0] TSS_RST_SRC = 8'h00;
    localparam logic [7:0] TSS_RST_TRIG = 8'h00;
    localparam logic [7:0] TSS_RST_CORR = 8'h00;
    // =========================================================
    // Field positions, disable register
    localparam int TSS_DIS_GLOBAL = 5;
    localparam int TSS_DIS_COARSE_MIXER_SRC = 7;
    // Field positions, source register
    localparam int TSS_SRC_GLOBAL = 5;
    // Field positions, trigger register
    localparam int TSS_TRIG_GLOBAL = 6;
    // Field positions, correction register
    localparam int TSS_CORR_OFF_HOLD = 0;
    localparam int TSS_CORR_GP_HOLD = 1;
    localparam int TSS_CORR_OFF_EN = 6;
    localparam int TSS_CORR_GP_EN = 7;
    // =========================================================
    // Block indices inside the per-block vectors
    localparam int TSS_NBLK = 5;
    localparam int TSS_BLK_FIFO = 0;
    localparam int TSS_BLK_COARSE_MIXER = 1;
    localparam int TSS_BLK_DIV = 2;
    localparam int TSS_BLK_OFF = 3;
    localparam int TSS_BLK_GP = 4;
    // =========================================================
    // Pointer spacing after a buffer sync
    localparam int TSS_FIFO_GAP = 4;
endpackage : tss_pkg

// ==== tss_shadow.sv ====
// Shadow register that withholds correction words until a sync.
// Assumes live words come from registers on the same clock.
module tss_shadow
    import tss_pkg::*;
#(
    parameter int W = 26,
    parameter int BLK = 3
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Events and hold flags
    tss_evt_if.dst evt,
    // Words
    input wire logic [W-1:0] live,
    output logic [W-1:0] active
);
    typedef struct packed {
        logic [W-1:0] word;
    } tss_sh_t;
    tss_sh_t st;
    tss_sh_t next_st;
    logic hold;

    assign hold = (BLK == TSS_BLK_OFF) ? evt.off_hold : evt.gp_hold;

    // =========================================================
    // Follow live words, or wait for this block's sync
    always_comb
    begin
        next_st = st;
        if (!hold || evt.pulse[BLK])
            next_st.word = live;
    end

    // State register
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            st <= '0;
        else
            st <= next_st;
    end

    assign active = st.word;

    // Held words do not move without a sync
    a_shadow_held: assert property (@(posedge clk_sys) disable iff (!resetn)
        hold && !evt.pulse[BLK] |=> $stable(active))
        else $error("held correction word changed without sync");
    // A sync takes the live word
    a_shadow_load: assert property (@(posedge clk_sys) disable iff (!resetn)
        evt.pulse[BLK] |=> active == $past(live))
        else $error("sync did not load the correction word");
endmodule : tss_shadow

// ==== tss_sync_ctrl.sv ====
// Transmit sync distribution control: registers, event routing,
// buffer pointer init, coarse mixer phase and clock divider phase.
// Assumes a register port decoded from the host serial interface on
// clk_sys, and a sync pin asynchronous to clk_sys.
//
// Overview of operation
// - Global-off bit hands syncing to each block's own disable and source.
// - Global mode: one selected rising edge syncs all five blocks together.
// - Global source picks pin at 0, global soft trigger at 1.
// - Global soft trigger 0-to-1 write syncs all blocks when selected.
// - Per-block disable suppresses that block, only while global is off.
// - Buffer sync sets write and read pointers four apart.
// - Coarse mixer sync sets mixing phase for both channels at once.
// - Coarse mixer source picks pin clear, its soft trigger edge set.
// - Buffer source picks pin at 0, its soft trigger edge at 1.
// - Divider source picks pin clear, its soft trigger edge set.
// - Offset source picks pin clear, its soft trigger edge set.
// - Gain/phase source picks pin clear, its soft trigger edge set.
// - Block soft trigger fires only in block mode, enabled, soft source.
// - Offset hold keeps new offset words back until offset sync.
// - Gain/phase hold keeps new words back until gain/phase sync.
// - Offset enable switches offset correction for both channels.
// - Gain/phase enable gives zero output until software writes gains; here the bit only drives gain_phase_corr_enable.
// - All sync settings are common to both transmit channels.
// - Coarse mixer sync loads the programmed two-bit phase.
// - Divider sync loads the programmed phase ANDed with the divider terminal count set by the interpolation mode.
module tss_sync_ctrl
    import tss_pkg::*;
#(
    parameter int PTRW = 3,
    parameter int OFFW = 13,
    parameter int GAINW = 11,
    parameter int PHW = 10
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Register port from the serial interface
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [8:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // External sync pin
    input wire logic sync_pin,
    // Programmed values from neighbouring registers
    input wire logic [1:0] coarse_mixer_phase_value,
    input wire logic [1:0] div_phase_value,
    input wire logic [1:0] interp_mode,
    input wire logic [OFFW-1:0] offset_a_live,
    input wire logic [OFFW-1:0] offset_b_live,
    input wire logic [GAINW-1:0] chan_a_gain_word,
    input wire logic [GAINW-1:0] chan_b_gain_word,
    input wire logic [PHW-1:0] phase_word_live,
    // Per-block sync pulses
    output logic [4:0] sync_pulse,
    // Transmit buffer pointer load
    output logic fifo_ptr_load,
    output logic [PTRW-1:0] fifo_wr_init,
    output logic [PTRW-1:0] fifo_rd_init,
    // Coarse mixer and divider
    output logic [1:0] mixer_phase,
    output logic [1:0] div_count,
    output logic div_tick,
    // Quadrature correction
    output logic offset_corr_enable,
    output logic gain_phase_corr_enable,
    output logic [2*OFFW-1:0] offset_active,
    output logic [2*GAINW+PHW-1:0] gain_phase_active
);
    typedef struct packed {
        logic [7:0] dis;
        logic [7:0] src;
        logic [7:0] trig;
        logic [7:0] corr;
        logic [7:0] trig_last;
        logic [4:0] pulse;
        logic [PTRW-1:0] wr_init;
        logic [PTRW-1:0] rd_init;
        logic [1:0] mix;
        logic [1:0] div;
        logic tick;
        logic [7:0] rdata;
        logic rvalid;
    } tss_st_t;

    tss_st_t st;
    tss_st_t next_st;
    tss_evt_if evt ();

    logic pin_rise;
    logic [7:0] trig_rise;
    logic [4:0] blk_src;
    logic glob_evt;
    logic [4:0] evt_vec;
    logic [1:0] div_max;

    // =========================================================
    // Pin synchroniser
    tss_pin_sync u_pin
    (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .pin(sync_pin),
        .rise(pin_rise)
    );

    // =========================================================
    // Event routing
    // Soft trigger edges: only a fresh 0-to-1 counts
    assign trig_rise = st.trig & ~st.trig_last;
    // Source bit per block; the mixer's lives in the disable register
    assign blk_src = {st.src[TSS_BLK_GP], st.src[TSS_BLK_OFF],
                      st.src[TSS_BLK_DIV], st.dis[TSS_DIS_COARSE_MIXER_SRC],
                      st.src[TSS_BLK_FIFO]};
    // Global trigger: pin or soft bit
    assign glob_evt = st.src[TSS_SRC_GLOBAL] ?
                      trig_rise[TSS_TRIG_GLOBAL] : pin_rise;

    // One event per block, common to both channels
    generate
        for (genvar b = 0; b < TSS_NBLK; b++)
        begin : g_blk
            always_comb
            begin
                if (!st.dis[TSS_DIS_GLOBAL])
                    evt_vec[b] = glob_evt;
                else if (st.dis[b])
                    evt_vec[b] = 1'b0;
                else if (blk_src[b])
                    evt_vec[b] = trig_rise[b];
                else
                    evt_vec[b] = pin_rise;
            end
        end
    endgenerate

    // Divider terminal count from the interpolation factor
    always_comb
    begin
        unique case (interp_mode)
            2'h0: div_max = 2'h0;
            2'h1: div_max = 2'h1;
            default: div_max = 2'h3;
        endcase
    end

    // =========================================================
    // Next state
    always_comb
    begin
        next_st = st;
        next_st.rvalid = 1'b0;
        next_st.trig_last = st.trig;
        next_st.pulse = evt_vec;
        // Register writes
        if (reg_wr)
        begin
            unique case (reg_addr)
                TSS_ADDR_DIS: next_st.dis = reg_wdata;
                TSS_ADDR_SRC: next_st.src = reg_wdata;
                TSS_ADDR_TRIG: next_st.trig = reg_wdata;
                TSS_ADDR_CORR: next_st.corr = reg_wdata;
                default: next_st.rvalid = 1'b0;
            endcase
        end
        // Register reads, unmapped reads as zero
        if (reg_rd)
        begin
            next_st.rvalid = 1'b1;
            unique case (reg_addr)
                TSS_ADDR_DIS: next_st.rdata = st.dis;
                TSS_ADDR_SRC: next_st.rdata = st.src;
                TSS_ADDR_TRIG: next_st.rdata = st.trig;
                TSS_ADDR_CORR: next_st.rdata = st.corr;
                default: next_st.rdata = 8'h00;
            endcase
        end
        // Buffer pointers four apart
        if (evt_vec[TSS_BLK_FIFO])
        begin
            next_st.rd_init = '0;
            next_st.wr_init = PTRW'(TSS_FIFO_GAP);
        end
        // Coarse mixer phase load
        if (evt_vec[TSS_BLK_COARSE_MIXER])
            next_st.mix = coarse_mixer_phase_value;
        // Divider: load phase on sync, else count
        if (evt_vec[TSS_BLK_DIV])
            next_st.div = div_phase_value & div_max;
        else if (st.div >= div_max)
            next_st.div = 2'h0;
        else
            next_st.div = st.div + 2'h1;
        next_st.tick = (next_st.div == 2'h0);
    end

    // State register
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            st <= '0;
            st.dis <= TSS_RST_DIS;
            st.src <= TSS_RST_SRC;
            st.trig <= TSS_RST_TRIG;
            st.corr <= TSS_RST_CORR;
        end
        else
            st <= next_st;
    end

    // =========================================================
    // Correction shadows
    assign evt.pulse = st.pulse;
    assign evt.off_hold = st.corr[TSS_CORR_OFF_HOLD];
    assign evt.gp_hold = st.corr[TSS_CORR_GP_HOLD];

    // Offset words for both channels
    tss_shadow #(.W(2*OFFW), .BLK(TSS_BLK_OFF)) u_off
    (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .evt(evt),
        .live({offset_b_live, offset_a_live}),
        .active(offset_active)
    );

    // Gain and phase words
    tss_shadow #(.W(2*GAINW+PHW), .BLK(TSS_BLK_GP)) u_gp
    (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .evt(evt),
        .live({phase_word_live, chan_b_gain_word, chan_a_gain_word}),
        .active(gain_phase_active)
    );

    // =========================================================
    // Outputs
    assign sync_pulse = st.pulse;
    assign fifo_ptr_load = st.pulse[TSS_BLK_FIFO];
    assign fifo_wr_init = st.wr_init;
    assign fifo_rd_init = st.rd_init;
    assign mixer_phase = st.mix;
    assign div_count = st.div;
    assign div_tick = st.tick;
    assign offset_corr_enable = st.corr[TSS_CORR_OFF_EN];
    assign gain_phase_corr_enable = st.corr[TSS_CORR_GP_EN];
    assign reg_rdata = st.rdata;
    assign reg_rvalid = st.rvalid;

    // =========================================================
    // Checks
    sequence s_soft_write(int bitn);
        reg_wr && reg_addr == TSS_ADDR_TRIG && !st.trig[bitn] && reg_wdata[bitn];
    endsequence

    sequence s_global_pin;
        !st.dis[TSS_DIS_GLOBAL] && !st.src[TSS_SRC_GLOBAL] && pin_rise;
    endsequence

    a_global_all_sync: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_global_pin |=> sync_pulse == 5'h1f)
        else $error("global pin edge did not sync all blocks");

    a_global_soft_sync: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_soft_write(TSS_TRIG_GLOBAL) ##1 (!st.dis[TSS_DIS_GLOBAL]
        && st.src[TSS_SRC_GLOBAL]) |=> sync_pulse == 5'h1f)
        else $error("global soft trigger did not sync all blocks");

    a_global_src_pin: assert property (@(posedge clk_sys) disable iff (!resetn)
        !st.dis[TSS_DIS_GLOBAL] && st.src[TSS_SRC_GLOBAL]
        && !trig_rise[TSS_TRIG_GLOBAL] |=> sync_pulse == 5'h00)
        else $error("pin reached blocks while soft source selected");

    a_block_off_quiet: assert property (@(posedge clk_sys) disable iff (!resetn)
        st.dis[TSS_DIS_GLOBAL] && st.dis[TSS_BLK_FIFO]
        |=> !sync_pulse[TSS_BLK_FIFO])
        else $error("disabled buffer block was synced");

    a_div_soft_sync: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_soft_write(TSS_BLK_DIV) ##1 (st.dis[TSS_DIS_GLOBAL]
        && !st.dis[TSS_BLK_DIV] && st.src[TSS_BLK_DIV])
        |=> sync_pulse[TSS_BLK_DIV] ##1 !sync_pulse[TSS_BLK_DIV])
        else $error("divider soft trigger gave no single sync");

    a_coarse_mixer_pin_src: assert property (@(posedge clk_sys) disable iff (!resetn)
        st.dis[TSS_DIS_GLOBAL] && !st.dis[TSS_BLK_COARSE_MIXER]
        && !st.dis[TSS_DIS_COARSE_MIXER_SRC] && pin_rise
        |=> sync_pulse[TSS_BLK_COARSE_MIXER])
        else $error("mixer did not follow the pin");

    a_fifo_gap: assert property (@(posedge clk_sys) disable iff (!resetn)
        fifo_ptr_load |-> fifo_wr_init - fifo_rd_init == PTRW'(TSS_FIFO_GAP))
        else $error("buffer pointers not four apart");

    a_mix_phase_load: assert property (@(posedge clk_sys) disable iff (!resetn)
        sync_pulse[TSS_BLK_COARSE_MIXER] |-> mixer_phase == $past(coarse_mixer_phase_value))
        else $error("mixer phase not loaded on sync");

    a_div_phase_load: assert property (@(posedge clk_sys) disable iff (!resetn)
        sync_pulse[TSS_BLK_DIV] && interp_mode == 2'h2 && $stable(interp_mode)
        |-> div_count == $past(div_phase_value))
        else $error("divider phase not loaded on sync");

    a_corr_enable: assert property (@(posedge clk_sys) disable iff (!resetn)
        reg_wr && reg_addr == TSS_ADDR_CORR
        |=> offset_corr_enable == $past(reg_wdata[TSS_CORR_OFF_EN])
        && gain_phase_corr_enable == $past(reg_wdata[TSS_CORR_GP_EN]))
        else $error("correction enables not taken from write");

    a_read_answer: assert property (@(posedge clk_sys) disable iff (!resetn)
        reg_rd && reg_addr == TSS_ADDR_DIS |=> reg_rvalid && reg_rdata == $past(st.dis))
        else $error("read of disable register wrong");
endmodule : tss_sync_ctrl

// ==== tss_sync_ctrl_tb_top.sv ====
// Self-checking bench for the transmit sync distribution control.
// Assumes tss_pkg, tss_host_model and the design files are compiled first.
module tss_sync_ctrl_tb_top import tss_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    // =========================================================
    // Signals
    logic clk_sys;
    logic resetn;
    logic reg_wr, reg_rd, reg_rvalid, sync_pin;
    logic [8:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [1:0] coarse_mixer_ph, div_ph, interp;
    logic [12:0] off_a, off_b;
    logic [10:0] gain_a, gain_b;
    logic [9:0] ph_w;
    logic [4:0] sync_pulse;
    logic fifo_ptr_load, div_tick, off_en, gp_en, got_tick;
    logic [2:0] fifo_wr_init, fifo_rd_init;
    logic [1:0] mixer_phase, div_count, got_div;
    logic [25:0] offset_active, old_off;
    logic [31:0] gain_phase_active, old_gp;
    int bad_count = 0;
    int samples_checked = 0;

    // =========================================================
    // Clock, design and partner
    always #50 clk_sys = ~clk_sys;

    tss_sync_ctrl #(.PTRW(3), .OFFW(13), .GAINW(11), .PHW(10)) tss_sync_ctrl_i (
        .clk_sys(clk_sys), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .sync_pin(sync_pin), .coarse_mixer_phase_value(coarse_mixer_ph), .div_phase_value(div_ph),
        .interp_mode(interp), .offset_a_live(off_a), .offset_b_live(off_b),
        .chan_a_gain_word(gain_a), .chan_b_gain_word(gain_b), .phase_word_live(ph_w),
        .sync_pulse(sync_pulse), .fifo_ptr_load(fifo_ptr_load), .fifo_wr_init(fifo_wr_init),
        .fifo_rd_init(fifo_rd_init), .mixer_phase(mixer_phase), .div_count(div_count),
        .div_tick(div_tick), .offset_corr_enable(off_en), .gain_phase_corr_enable(gp_en),
        .offset_active(offset_active), .gain_phase_active(gain_phase_active));

    tss_host_model tss_host_model_i (
        .clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sync_pin(sync_pin));

    // =========================================================
    // Checking helpers
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic rchk(input logic [8:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        tss_host_model_i.rd(addr, d, v);
        chk("read valid", 32'h1, {31'h0, v});
        chk("read data", {24'h0, exp}, {24'h0, d});
    endtask : rchk

    // Watch up to eight cycles for a pulse; it must match and last one cycle
    task automatic expect_sync(input logic [4:0] exp, input string what);
        logic [4:0] seen;
        logic got_load;
        seen = 5'h00;
        got_load = 1'b0;
        for (int i = 0; i < 8 && seen === 5'h00; i++)
        begin
            @(posedge clk_sys);
            #1;
            seen = sync_pulse;
            got_div = div_count;
            got_tick = div_tick;
            got_load = fifo_ptr_load;
        end
        chk(what, {27'h0, exp}, {27'h0, seen});
        chk("buffer load", {31'h0, exp[0]}, {31'h0, got_load});
        if (seen !== 5'h00)
        begin
            @(posedge clk_sys);
            #1;
            chk("pulse width", 32'h0, {27'h0, sync_pulse});
        end
    endtask : expect_sync

    // Closing report
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    // Watchdog well beyond the expected run of under a thousand cycles
    initial
    begin
        #(5000 * 100);
        bad_count++;
        wrap_up();
    end

    // =========================================================
    // Main sequence
    initial
    begin
        clk_sys = 1'b0;
        resetn = 1'b0;
        coarse_mixer_ph = 2'h2;
        div_ph = 2'h3;
        interp = 2'h2;
        off_a = 13'h0123;
        off_b = 13'h1abc;
        gain_a = 11'h400;
        gain_b = 11'h400;
        ph_w = 10'h015;
        repeat (8) @(posedge clk_sys);
        #1;
        resetn = 1'b1;
        // Reset values, unmapped space, enables
        rchk(TSS_ADDR_DIS, TSS_RST_DIS);
        rchk(TSS_ADDR_SRC, TSS_RST_SRC);
        rchk(TSS_ADDR_TRIG, TSS_RST_TRIG);
        rchk(TSS_ADDR_CORR, TSS_RST_CORR);
        tss_host_model_i.wr(9'h10f, 8'hff);
        rchk(9'h10f, 8'h00);
        tss_host_model_i.wr(TSS_ADDR_CORR, 8'hc0);
        rchk(TSS_ADDR_CORR, 8'hc0);
        chk("offset enable", 32'h1, {31'h0, off_en});
        chk("gain phase enable", 32'h1, {31'h0, gp_en});
        chk("offset follows", {6'h0, off_b, off_a}, {6'h0, offset_active});
        chk("gain phase follows", {ph_w, gain_b, gain_a}, gain_phase_active);
        // Global mode from the pin
        tss_host_model_i.pin_rise();
        expect_sync(5'h1f, "global pin");
        chk("pointer gap", TSS_FIFO_GAP, {29'h0, 3'(fifo_wr_init - fifo_rd_init)});
        chk("pointer write", TSS_FIFO_GAP, {29'h0, fifo_wr_init});
        chk("mixer phase", {30'h0, coarse_mixer_ph}, {30'h0, mixer_phase});
        chk("divider phase", {30'h0, div_ph & 2'h3}, {30'h0, got_div});
        chk("divider tick", 32'h0, {31'h0, got_tick});
        // Global mode from the soft trigger; pin then ignored
        coarse_mixer_ph = 2'h1;
        div_ph = 2'h2;
        interp = 2'h1;
        tss_host_model_i.wr(TSS_ADDR_SRC, 8'h20);
        tss_host_model_i.pin_rise();
        expect_sync(5'h00, "pin with soft source");
        tss_host_model_i.trig(8'h40);
        expect_sync(5'h1f, "global soft");
        chk("mixer phase", {30'h0, coarse_mixer_ph}, {30'h0, mixer_phase});
        chk("divider phase", {30'h0, div_ph & 2'h1}, {30'h0, got_div});
        chk("divider tick", 32'h1, {31'h0, got_tick});
        tss_host_model_i.wr(TSS_ADDR_TRIG, 8'h40);
        expect_sync(5'h00, "same value again");
        // Block mode, every block from its own soft trigger
        tss_host_model_i.wr(TSS_ADDR_DIS, 8'ha0);
        tss_host_model_i.wr(TSS_ADDR_SRC, 8'h1d);
        tss_host_model_i.pin_rise();
        expect_sync(5'h00, "pin with block soft sources");
        for (int b = 0; b < TSS_NBLK; b++)
        begin
            tss_host_model_i.trig(8'(1 << b));
            expect_sync(5'(1 << b), "block soft");
        end
        tss_host_model_i.trig(8'h40);
        expect_sync(5'h00, "global soft in block mode");
        tss_host_model_i.wr(TSS_ADDR_DIS, 8'ha1);
        tss_host_model_i.trig(8'h01);
        expect_sync(5'h00, "disabled buffer");
        // Block mode from the pin, divider disabled
        tss_host_model_i.wr(TSS_ADDR_DIS, 8'h24);
        tss_host_model_i.wr(TSS_ADDR_SRC, 8'h00);
        tss_host_model_i.trig(8'h1f);
        expect_sync(5'h00, "soft with pin sources");
        tss_host_model_i.pin_rise();
        expect_sync(5'h1b, "block pin");
        // Per-block disables have no effect in global mode
        tss_host_model_i.wr(TSS_ADDR_DIS, 8'h1f);
        tss_host_model_i.pin_rise();
        expect_sync(5'h1f, "disables ignored globally");
        // Held correction words wait for their own sync
        tss_host_model_i.wr(TSS_ADDR_CORR, 8'hc3);
        old_off = offset_active;
        old_gp = gain_phase_active;
        off_a = 13'h0456;
        off_b = 13'h0789;
        gain_a = 11'h3ff;
        gain_b = 11'h155;
        ph_w = 10'h2aa;
        repeat (4) @(posedge clk_sys);
        #1;
        chk("offset held", {6'h0, old_off}, {6'h0, offset_active});
        chk("gain phase held", old_gp, gain_phase_active);
        tss_host_model_i.wr(TSS_ADDR_DIS, 8'h20);
        tss_host_model_i.wr(TSS_ADDR_SRC, 8'h08);
        tss_host_model_i.trig(8'h08);
        expect_sync(5'h08, "offset soft");
        chk("offset applied", {6'h0, off_b, off_a}, {6'h0, offset_active});
        chk("gain phase still held", old_gp, gain_phase_active);
        tss_host_model_i.wr(TSS_ADDR_SRC, 8'h10);
        tss_host_model_i.trig(8'h10);
        expect_sync(5'h10, "gain phase soft");
        chk("gain phase applied", {ph_w, gain_b, gain_a}, gain_phase_active);
        wrap_up();
    end
endmodule : tss_sync_ctrl_tb_top
